// ### include/sema_pkg.sv
// package: constants and carrier types for the dual-port semaphore
package sema_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned SEL_W      = 4;
  localparam int unsigned FLAG_BIT   = 0;
  localparam logic        FLAG_FREE  = 1'h0;
  localparam logic        FLAG_TAKEN = 1'h1;
  localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

  // one wishbone slave request, as seen by the device
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] dat;
  } wb_req_t;

  // one wishbone slave answer
  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
  } wb_rsp_t;

  // decoded request of one port
  typedef struct packed {
    logic rd;
    logic rel;
  } port_op_t;

  // semaphore flags
  typedef struct packed {
    logic taken;
    logic side_a_owner_flag;
    logic side_b_owner_flag;
  } sema_state_t;

  // a single-beat request is live while cycle and strobe are both high
  function automatic port_op_t decode_op(input wb_req_t q);
    port_op_t o;
    o.rd  = q.cyc & q.stb & ~q.we;
    o.rel = q.cyc & q.stb & q.we & (q.dat[FLAG_BIT] == FLAG_FREE);
    return o;
  endfunction
endpackage

// ### rtl/sema_port.sv
// wishbone slave port: one-cycle acknowledge and registered read data
`timescale 1ns/1ps
`default_nettype none
module sema_port
  import sema_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire wb_req_t req,
  input  wire logic    rd_bit,
  output wb_rsp_t      rsp
);
  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
  } port_st_t;

  port_st_t st_r;
  port_st_t st_nxt;

  ////////////////////////////////////////////////////////////////
  // ack one cycle after strobe, dropped between beats so a held
  // strobe is not acknowledged twice
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = req.cyc & req.stb & ~st_r.ack;
    st_nxt.dat = DATA_ZERO;
    if (req.cyc & req.stb & ~req.we & ~st_r.ack) begin
      st_nxt.dat[FLAG_BIT] = rd_bit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp.ack = st_r.ack;
  assign rsp.dat = st_r.dat;
endmodule
`default_nettype wire

// ### rtl/sema_core.sv
// semaphore flags: grant, refuse and release with port a priority
`timescale 1ns/1ps
`default_nettype none
module sema_core
  import sema_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire port_op_t op_a,
  input  wire port_op_t op_b,
  output logic          rd_bit_a,
  output logic          rd_bit_b,
  output sema_state_t   state
);
  sema_state_t st_r;
  sema_state_t st_nxt;

  ////////////////////////////////////////////////////////////////
  // read value: a sees the current flag, b also loses to a same-cycle a read
  always_comb begin
    rd_bit_a = st_r.taken;
    rd_bit_b = st_r.taken | op_a.rd;
  end

  // release from either side clears everything; a read of a free flag still
  // grants beside a release, because that reader was shown 0 and owns it now
  always_comb begin
    st_nxt = st_r;
    if (op_a.rel | op_b.rel) begin
      st_nxt = '0;
    end
    if (!st_r.taken && op_a.rd) begin
      st_nxt.taken             = FLAG_TAKEN;
      st_nxt.side_a_owner_flag = 1'h1;
    end else if (!st_r.taken && op_b.rd) begin
      st_nxt.taken             = FLAG_TAKEN;
      st_nxt.side_b_owner_flag = 1'h1;
    end
    // taken: no new grant until release; writes of one change nothing
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign state = st_r;
endmodule
`default_nettype wire

// ### rtl/ownership_flag_unit.sv
// top: one-bit semaphore shared by two wishbone slave ports
// Summary of operation
// - free semaphore reads 0 and is granted to the reader.
// - taken semaphore reads 1 on either port.
// - the owner reading again gets 1.
// - simultaneous reads: port a served first.
// - writing 0 releases, clearing taken and both owner flags.
// - writing 1 changes nothing.
// - either port may release, whoever owns it.
// - taken plus per-side owner flags; grant sets taken and owner together.
// - a read of the free flag from either side sets taken; writes never do.
// - grant only on first read after free.
// - no grant to either side while taken.
// - memory buffer is never gated; ownership only reported.
// - only normal acknowledge terminates cycles; no error or retry.
// - one flag bit (bit 0) on each 32-bit single read/write port.
`timescale 1ns/1ps
`default_nettype none
module ownership_flag_unit
  import sema_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              a_cyc_i,
  input  wire logic              a_stb_i,
  input  wire logic              a_we_i,
  input  wire logic [SEL_W-1:0]  a_sel_i,
  input  wire logic [DATA_W-1:0] a_dat_i,
  output logic [DATA_W-1:0]      a_dat_o,
  output logic                   a_ack_o,
  output logic                   a_err_o,
  output logic                   a_rty_o,
  input  wire logic              b_cyc_i,
  input  wire logic              b_stb_i,
  input  wire logic              b_we_i,
  input  wire logic [SEL_W-1:0]  b_sel_i,
  input  wire logic [DATA_W-1:0] b_dat_i,
  output logic [DATA_W-1:0]      b_dat_o,
  output logic                   b_ack_o,
  output logic                   b_err_o,
  output logic                   b_rty_o,
  output logic                   taken_o,
  output logic                   side_a_owner_flag,
  output logic                   side_b_owner_flag
);
  wb_req_t     req_a;
  wb_req_t     req_b;
  wb_rsp_t     rsp_a;
  wb_rsp_t     rsp_b;
  port_op_t    op_a;
  port_op_t    op_b;
  logic        rd_bit_a;
  logic        rd_bit_b;
  sema_state_t state;

  ////////////////////////////////////////////////////////////////
  // gather the pins; select lanes are carried but the flag is
  // written whatever lanes are set, granularity does not matter for one bit
  assign req_a = '{cyc: a_cyc_i, stb: a_stb_i, we: a_we_i, sel: a_sel_i, dat: a_dat_i};
  assign req_b = '{cyc: b_cyc_i, stb: b_stb_i, we: b_we_i, sel: b_sel_i, dat: b_dat_i};

  // only the first beat of a strobe acts; the ack beat is ignored
  always_comb begin
    op_a = decode_op(req_a);
    op_b = decode_op(req_b);
    if (rsp_a.ack) begin
      op_a = '0;
    end
    if (rsp_b.ack) begin
      op_b = '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  sema_port u_port_a (
    .clk    (clk),
    .rst    (rst),
    .req    (req_a),
    .rd_bit (rd_bit_a),
    .rsp    (rsp_a)
  );

  sema_port u_port_b (
    .clk    (clk),
    .rst    (rst),
    .req    (req_b),
    .rd_bit (rd_bit_b),
    .rsp    (rsp_b)
  );

  sema_core u_core (
    .clk      (clk),
    .rst      (rst),
    .op_a     (op_a),
    .op_b     (op_b),
    .rd_bit_a (rd_bit_a),
    .rd_bit_b (rd_bit_b),
    .state    (state)
  );

  ////////////////////////////////////////////////////////////////
  // outputs; nothing here touches the shared buffer itself
  assign a_dat_o           = rsp_a.dat;
  assign a_ack_o           = rsp_a.ack;
  assign b_dat_o           = rsp_b.dat;
  assign b_ack_o           = rsp_b.ack;
  assign a_err_o           = 1'h0;
  assign a_rty_o           = 1'h0;
  assign b_err_o           = 1'h0;
  assign b_rty_o           = 1'h0;
  assign taken_o           = state.taken;
  assign side_a_owner_flag = state.side_a_owner_flag;
  assign side_b_owner_flag = state.side_b_owner_flag;
endmodule
`default_nettype wire

// ### verif/wb_master_model.sv
// wishbone master model: single read or write beats
`timescale 1ns/1ps
`default_nettype none
module wb_master_model (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [3:0]       sel,
  output logic [31:0]      wdat
);
  // idle at time zero
  initial begin
    {cyc, stb, we, sel, wdat} = '0;
  end
  // beat held until ack is seen or 8 cycles pass; released data toggles so stale data never looks valid
  task automatic xfer(input logic w, input logic [31:0] d, output logic [31:0] q, output bit ok);
    ok = 0;
    @(negedge clk);
    {cyc, stb, we, sel, wdat} = {2'h3, w, 4'hf, d};
    for (int n = 0; n < 8 && !ok; n++) begin
      @(negedge clk);
      ok = (ack === 1'b1);
      q = rdat;
    end
    @(negedge clk);
    {cyc, stb, we} = '0;
    wdat = ~wdat;
  endtask
endmodule
`default_nettype wire

// ### verif/ownership_flag_unit_asserts.sv
// checker: grant, refusal, release and termination of the semaphore ports
`timescale 1ns/1ps
`default_nettype none
module ownership_flag_unit_asserts
  import sema_pkg::*;
(
  input wire logic clk, rst, a_cyc_i, a_stb_i, a_we_i, b_cyc_i, b_stb_i, b_we_i,
  input wire logic [DATA_W-1:0] a_dat_i, b_dat_i, a_dat_o, b_dat_o,
  input wire logic a_ack_o, b_ack_o, a_err_o, a_rty_o, b_err_o, b_rty_o,
  input wire logic taken_o, side_a_owner_flag, side_b_owner_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a strobe still high in its ack cycle is not a new beat
  wire a_go  = a_cyc_i & a_stb_i & ~a_ack_o;
  wire b_go  = b_cyc_i & b_stb_i & ~b_ack_o;
  wire a_rel = a_go & a_we_i & ~a_dat_i[0];
  wire b_rel = b_go & b_we_i & ~b_dat_i[0];
  wire a_rd  = a_go & ~a_we_i;
  wire b_rd  = b_go & ~b_we_i;
  sequence s_a_wins;
    a_ack_o && a_dat_o == DATA_ZERO && side_a_owner_flag && !side_b_owner_flag;
  endsequence
  sequence s_b_busy;
    b_ack_o && b_dat_o == 32'h1;
  endsequence
  a_ack_next: assert property (a_go |=> a_ack_o) else $error("a ack late");
  a_b_ack: assert property (b_go |=> b_ack_o) else $error("b ack late");
  a_no_abnormal: assert property (!(a_err_o | a_rty_o | b_err_o | b_rty_o))
    else $error("abnormal end");
  a_free_grant: assert property (a_go && !a_we_i && !taken_o |=> s_a_wins)
    else $error("no grant");
  a_owner_reread: assert property (a_rd && side_a_owner_flag |=> a_ack_o
    && a_dat_o == 32'h1) else $error("owner reread not 1");
  a_tie_order: assert property (a_go && b_go && !a_we_i && !b_we_i && !taken_o
    |=> s_a_wins ##0 s_b_busy) else $error("tie lost");
  a_busy_one: assert property (b_go && !b_we_i && taken_o |=> s_b_busy)
    else $error("busy not 1");
  a_release_all: assert property ((a_rel || b_rel) && !(!taken_o && (a_rd || b_rd))
    |=> !taken_o && !side_a_owner_flag && !side_b_owner_flag) else $error("no release");
  a_one_inert: assert property (a_go && a_we_i && a_dat_i[0] && !b_go
    |=> $stable({taken_o, side_a_owner_flag, side_b_owner_flag})) else $error("1 acted");
  a_owner_taken: assert property (side_a_owner_flag | side_b_owner_flag |-> taken_o
    && !(side_a_owner_flag && side_b_owner_flag)) else $error("bad owners");
endmodule
`default_nettype wire

// ### verif/ownership_flag_unit_bench.sv
// bench: two master models contend for the semaphore
`timescale 1ns/1ps
`default_nettype none
module ownership_flag_unit_bench;
  import sema_pkg::*;
  logic clk, rst, a_cyc_i, a_stb_i, a_we_i, b_cyc_i, b_stb_i, b_we_i, taken_o;
  logic a_ack_o, a_err_o, a_rty_o, b_ack_o, b_err_o, b_rty_o, side_a_owner_flag, side_b_owner_flag;
  logic [SEL_W-1:0]  a_sel_i, b_sel_i;
  logic [DATA_W-1:0] a_dat_i, a_dat_o, b_dat_i, b_dat_o, qa, qb;
  int                failures, comparisons;
  ownership_flag_unit ownership_flag_unit_inst (.*);
  wb_master_model wb_a (.clk(clk), .ack(a_ack_o), .rdat(a_dat_o), .cyc(a_cyc_i),
    .stb(a_stb_i), .we(a_we_i), .sel(a_sel_i), .wdat(a_dat_i));
  wb_master_model wb_b (.clk(clk), .ack(b_ack_o), .rdat(b_dat_o), .cyc(b_cyc_i),
    .stb(b_stb_i), .we(b_we_i), .sel(b_sel_i), .wdat(b_dat_i));
  // clock; reset is driven in the main sequence
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish(input bit hung);
    failures += hung;
    $display("%0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic flags(input logic [2:0] exp);
    chk({29'h0, taken_o, side_a_owner_flag, side_b_owner_flag}, {29'h0, exp});
    chk({28'h0, a_err_o, a_rty_o, b_err_o, b_rty_o}, 32'h0);
  endtask
  // one beat on port a (side 0) or b (side 1); a hang ends the run
  task automatic acc(input bit side, w, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    bit ok;
    if (side) wb_b.xfer(w, d, q, ok);
    else wb_a.xfer(w, d, q, ok);
    if (!ok) tally_and_finish(1);
  endtask
  // a grants, owner a rereads 1 and b is refused, writing 1 inert, b releases with upper bits set
  task automatic t_grant;
    acc(0, 0, 0, qa);
    chk(qa, 32'h0);
    flags(3'h6);
    acc(0, 0, 0, qa);
    chk(qa, 32'h1);
    acc(1, 0, 0, qb);
    chk(qb, 32'h1);
    acc(1, 1, 32'h1, qb);
    flags(3'h6);
    acc(0, 1, 32'h1, qa);
    flags(3'h6);
    acc(1, 1, 32'hffff_fffe, qb);
    flags(3'h0);
    $display("grant test done");
  endtask
  // same-cycle reads, then b owns and a releases it
  task automatic t_tie;
    fork
      acc(0, 0, 0, qa);
      acc(1, 0, 0, qb);
    join
    chk(qa, 32'h0);
    chk(qb, 32'h1);
    flags(3'h6);
    acc(0, 1, 0, qa);
    acc(1, 0, 0, qb);
    chk(qb, 32'h0);
    flags(3'h5);
    acc(0, 1, 0, qa);
    flags(3'h0);
    $display("tie test done");
  endtask
  // main sequence: reset for three cycles, then the scenarios
  initial begin
    rst = 1;
    repeat (3) @(negedge clk);
    rst = 0;
    flags(3'h0);
    t_grant;
    t_tie;
    tally_and_finish(0);
  end
endmodule
bind ownership_flag_unit ownership_flag_unit_asserts ownership_flag_unit_asserts_inst (.*);
`default_nettype wire
